//--- inc/rbgp_consts.svh
// constants for the resonant bridge gate protection block
`ifndef RBGP_CONSTS_SVH
`define RBGP_CONSTS_SVH
`define RBGP_CLK_KHZ 20000
`define RBGP_BLANK_NS 400
`define RBGP_BLANK_CYC ((`RBGP_BLANK_NS * `RBGP_CLK_KHZ + 999999) / 1000000)
`define RBGP_MAXDT_NS 1000
`define RBGP_MAXDT_CYC ((`RBGP_MAXDT_NS * `RBGP_CLK_KHZ) / 1000000)
`define RBGP_AVGH_MS 2
`define RBGP_AVGL_MS 50
`define RBGP_AVGH_CYC (`RBGP_AVGH_MS * `RBGP_CLK_KHZ)
`define RBGP_AVGL_CYC (`RBGP_AVGL_MS * `RBGP_CLK_KHZ)
`define RBGP_IGNORE_CYC 4'hF
`define RBGP_OFS_CTRL 4'h0
`define RBGP_OFS_BURST 4'h4
`define RBGP_OFS_STATUS 4'h8
`define RBGP_OFS_OCP 4'hC
`define RBGP_CTRL_EN 0
`define RBGP_CTRL_RESTART 1
`define RBGP_CTRL_RST 1'b1
`define RBGP_BURST_RST 24'h04_00_10
`define RBGP_OCP_RST 4'h4
`define RBGP_RESP_OK 2'h0
`define RBGP_RESP_ERR 2'h2
`endif

//--- inc/rbgp_pkg.sv
// types shared by the resonant bridge gate protection block
package rbgp_pkg;
  typedef enum logic [2:0] {GS_IDLE = 3'b000, GS_HI_ON = 3'b001, GS_DT_HI = 3'b010,
    GS_LO_ON = 3'b011, GS_DT_LO = 3'b100} rbgp_gate_t;
  typedef enum logic [1:0] {SU_JFET = 2'b00, SU_SUPPLY = 2'b01, SU_RUN = 2'b10} rbgp_start_t;
  typedef struct packed {
    logic slew_done;
    logic resonant_current_sign;
    logic peak_overcurrent;
    logic avg_overcurrent_high;
    logic avg_overcurrent_low;
    logic boot_uv;
    logic supply_uv;
    logic over_temp;
    logic supply_start;
    logic pfc_ready;
    logic bulk_cmp;
    logic cap_at_cm;
    logic ss_done;
  } rbgp_sense_t;
  typedef struct packed {
    logic over_temp;
    logic avg_low;
    logic avg_high;
    logic peak;
  } rbgp_fault_t;
endpackage : rbgp_pkg

//--- hdl/rbgp_top.sv
// gate timing and protection logic of a resonant half-bridge controller
//
// Contract
// - slew done in dead time starts next gate
// - else next polarity flip starts next gate
// - else maximum dead-time expiry starts next gate
// - sign at gate falls sets capacitive flag
// - flag holds until a clean half cycle
// - flag pulls soft-start pin down
// - count peak overcurrent cycles, shut down on reaching preset
// - high average overcurrent 2 ms shuts down
// - low average overcurrent 50 ms shuts down
// - bootstrap undervoltage holds upper gate off
// - gate supply undervoltage holds both gates off
// - overtemperature while switching stops switching
// - overtemperature during start-up turns JFET off
// - effort is larger of compensator, burst threshold
// - below threshold: fixed cycles, then stop
// - above threshold: switch continuously
// - before soft start done, ramp-limited compensator
// - last burst pulse ends at common mode
// - burst threshold programmable, follows input voltage
// - power-up enables start-up JFET
// - supply above start: JFET off, supply on
// - converter starts after power-factor stage ready
// - peak fault needs 4 consecutive cycles
// - ignore peak comparator first 15 cycles
// - ignore polarity edges in first 400ns
// - bulk overvoltage hysteresis from fault state
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rbgp_consts.svh"
module rbgp_top #(
  parameter int AVGH_CYC = `RBGP_AVGH_CYC,
  parameter int AVGL_CYC = `RBGP_AVGL_CYC
) (
  input wire logic aclk, // 20 MHz clock
  input wire logic aresetn, // sync reset, low
  input wire logic [3:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [3:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read valid
  input wire logic rready, // read ready
  input wire rbgp_pkg::rbgp_sense_t sense_in, // comparator pins
  input wire logic [7:0] loop_compensator_output, // compensator code
  input wire logic [7:0] soft_start_ramp, // soft-start ramp code
  input wire logic [7:0] bulk_sense, // input voltage code
  output logic upper_switch_on, // high-side gate
  output logic lower_switch_on, // low-side gate
  output logic capacitive_region_flag, // capacitive region seen
  output logic ss_pulldown, // soft-start pin pull-down
  output logic jfet_on, // start-up JFET enable
  output logic gate_supply_en, // regulated gate supply enable
  output logic bulk_overvoltage, // fault, also threshold select
  output logic [7:0] control_effort // selected control effort
);
  import rbgp_pkg::*;
  localparam int SW = $bits(rbgp_sense_t);
  localparam int CW = 21;
  if (AVGH_CYC < 2 || AVGL_CYC < 2 || AVGL_CYC >= (1 << CW))
  begin : g_bad
    $error("average overcurrent counts out of range");
  end
  logic [SW-1:0] sync1, sync2, sync3, sense_q; // three-stage synchronisers
  rbgp_sense_t sn; // filtered pin levels
  rbgp_gate_t state, next_state; // gate sequencer
  rbgp_start_t su, next_su; // start-up sequencer
  rbgp_fault_t fault; // latched shutdown faults
  logic [7:0] cnt; // cycles in gate state
  logic sign_prev; // last polarity level
  logic sign_edge; // polarity flipped
  logic dt_done; // dead time may end
  logic run_ok; // switching permitted
  logic hi_fall, lo_fall; // gate turn-off events
  logic ctrl_en, restart; // control bits
  logic [23:0] burst_cfg; // base, slope, cycles
  logic [3:0] ocp_preset; // peak cycle limit
  logic [15:0] slope_prod; // slope times input voltage
  logic [8:0] bmt_sum; // unsaturated threshold
  logic [7:0] burst_threshold; // adaptive burst threshold
  logic below; // compensator under threshold
  logic [7:0] bcnt; // pulses in this burst
  logic last_pulse, burst_stop; // burst end control
  logic peak_seen; // peak event in this cycle
  logic [3:0] start_cyc, consec; // blanking and run counters
  logic [CW-1:0] avgh_cnt, avgl_cnt; // average duration timers
  logic wr_go, ar_go; // bus accept strobes
  logic [31:0] rd_mux; // read data mux

  // per-bit synchroniser; a level counts once stages two and three agree
  for (genvar i = 0; i < SW; i++)
  begin : g_sync
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
        sense_q[i] <= 1'b0;
      end
      else
      begin
        sync1[i] <= sense_in[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i])
          sense_q[i] <= sync3[i];
      end
    end
  end
  assign sn = rbgp_sense_t'(sense_q);

  // switching gate; latched faults, bulk fault and gate supply undervoltage stop it
  assign run_ok = su == SU_RUN && ctrl_en && fault == '0 && !sn.bulk_cmp
    && !sn.supply_uv;
  assign sign_edge = sn.resonant_current_sign != sign_prev;
  // slew first, then a polarity flip past blanking, then the timer
  assign dt_done = sn.slew_done
    || (sign_edge && cnt >= 8'(`RBGP_BLANK_CYC))
    || cnt >= 8'(`RBGP_MAXDT_CYC - 1);
  assign hi_fall = state == GS_HI_ON && next_state != GS_HI_ON;
  assign lo_fall = state == GS_LO_ON && next_state != GS_LO_ON;

  // gate sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      GS_IDLE:
        if (run_ok && !burst_stop)
          next_state = GS_HI_ON;
      GS_HI_ON:
        if (!run_ok)
          next_state = GS_IDLE;
        else if (cnt >= control_effort)
          next_state = GS_DT_HI;
      GS_DT_HI:
        if (!run_ok)
          next_state = GS_IDLE;
        else if (dt_done)
          next_state = GS_LO_ON;
      GS_LO_ON:
        if (!run_ok)
          next_state = GS_IDLE;
        else if (last_pulse ? sn.cap_at_cm : cnt >= control_effort)
          next_state = GS_DT_LO;
      GS_DT_LO:
        if (!run_ok)
          next_state = GS_IDLE;
        else if (dt_done)
          next_state = burst_stop ? GS_IDLE : GS_HI_ON;
      default:
        next_state = GS_IDLE;
    endcase
  end

  // gate state, its timer and gate outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= GS_IDLE;
      cnt <= 8'h00;
      sign_prev <= 1'b0;
      upper_switch_on <= 1'b0;
      lower_switch_on <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sign_prev <= sn.resonant_current_sign;
      if (next_state != state)
        cnt <= 8'h00;
      else if (cnt != 8'hFF)
        cnt <= cnt + 8'h01;
      // undervoltage masks the gates directly
      upper_switch_on <= next_state == GS_HI_ON && !sn.boot_uv && !sn.supply_uv;
      lower_switch_on <= next_state == GS_LO_ON && !sn.supply_uv;
    end
  end

  // capacitive detection; each gate fall rewrites the flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      capacitive_region_flag <= 1'b0;
      ss_pulldown <= 1'b0;
    end
    else if (hi_fall || lo_fall)
    begin
      // clean half cycle clears it, so a single bad one holds it
      capacitive_region_flag <= hi_fall ^ sn.resonant_current_sign;
      ss_pulldown <= hi_fall ^ sn.resonant_current_sign;
    end
  end

  // adaptive burst threshold and control effort
  assign slope_prod = burst_cfg[15:8] * bulk_sense;
  assign bmt_sum = {1'b0, burst_cfg[7:0]} + {1'b0, slope_prod[15:8]};
  assign burst_threshold = bmt_sum[8] ? 8'hFF : bmt_sum[7:0];
  assign below = sn.ss_done && loop_compensator_output < burst_threshold;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      control_effort <= 8'h00;
    else if (!sn.ss_done)
      control_effort <= loop_compensator_output < soft_start_ramp ?
        loop_compensator_output : soft_start_ramp;
    else
      control_effort <= below ? burst_threshold : loop_compensator_output;
  end

  // burst pulse counting; stop once the last pulse ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bcnt <= 8'h00;
      last_pulse <= 1'b0;
      burst_stop <= 1'b0;
    end
    else if (!below)
    begin
      bcnt <= 8'h00;
      last_pulse <= 1'b0;
      burst_stop <= 1'b0;
    end
    else if (hi_fall)
    begin
      bcnt <= bcnt + 8'h01;
      if (bcnt + 8'h01 >= burst_cfg[23:16])
        last_pulse <= 1'b1;
    end
    else if (lo_fall && last_pulse)
    begin
      last_pulse <= 1'b0;
      burst_stop <= 1'b1;
    end
  end

  // peak events, checked once per cycle on the high-side half
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      peak_seen <= 1'b0;
      start_cyc <= 4'h0;
      consec <= 4'h0;
      fault.peak <= 1'b0;
    end
    else
    begin
      if (state != GS_HI_ON)
        peak_seen <= 1'b0;
      else if (sn.peak_overcurrent)
        peak_seen <= 1'b1;
      if (su != SU_RUN)
        start_cyc <= 4'h0;
      else if (hi_fall && start_cyc != `RBGP_IGNORE_CYC)
        start_cyc <= start_cyc + 4'h1;
      if (hi_fall && start_cyc == `RBGP_IGNORE_CYC)
        consec <= (peak_seen || sn.peak_overcurrent) ? consec + 4'h1 : 4'h0;
      if (hi_fall && start_cyc == `RBGP_IGNORE_CYC && (peak_seen || sn.peak_overcurrent)
          && consec + 4'h1 >= ocp_preset)
        fault.peak <= 1'b1;
      else if (restart)
        fault.peak <= 1'b0;
    end
  end

  // average overcurrent timers; a dropout restarts them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      avgh_cnt <= '0;
      avgl_cnt <= '0;
      fault.avg_high <= 1'b0;
      fault.avg_low <= 1'b0;
    end
    else
    begin
      avgh_cnt <= sn.avg_overcurrent_high ? avgh_cnt + CW'(1) : '0;
      avgl_cnt <= sn.avg_overcurrent_low ? avgl_cnt + CW'(1) : '0;
      if (sn.avg_overcurrent_high && avgh_cnt == CW'(AVGH_CYC - 1))
        fault.avg_high <= 1'b1;
      else if (restart)
        fault.avg_high <= 1'b0;
      if (sn.avg_overcurrent_low && avgl_cnt == CW'(AVGL_CYC - 1))
        fault.avg_low <= 1'b1;
      else if (restart)
        fault.avg_low <= 1'b0;
    end
  end

  // overtemperature latch and hysteretic bulk fault
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault.over_temp <= 1'b0;
      bulk_overvoltage <= 1'b0;
    end
    else
    begin
      // output selects the falling threshold while set
      bulk_overvoltage <= sn.bulk_cmp;
      if (sn.over_temp)
        fault.over_temp <= 1'b1;
      else if (restart)
        fault.over_temp <= 1'b0;
    end
  end

  // start-up sequencer
  always_comb
  begin
    next_su = su;
    unique case (su)
      SU_JFET:
        if (sn.supply_start)
          next_su = SU_SUPPLY;
      SU_SUPPLY:
        if (sn.pfc_ready)
          next_su = SU_RUN;
      SU_RUN:
        next_su = SU_RUN;
      default:
        next_su = SU_JFET;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      su <= SU_JFET;
      jfet_on <= 1'b0;
      gate_supply_en <= 1'b0;
    end
    else
    begin
      su <= next_su;
      jfet_on <= next_su == SU_JFET && !sn.over_temp;
      gate_supply_en <= next_su != SU_JFET;
    end
  end

  // bus write side; address and data taken together
  assign wr_go = awvalid && wvalid && !awready && !bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RBGP_RESP_OK;
      ctrl_en <= `RBGP_CTRL_RST;
      restart <= 1'b0;
      burst_cfg <= `RBGP_BURST_RST;
      ocp_preset <= `RBGP_OCP_RST;
    end
    else
    begin
      awready <= wr_go;
      wready <= wr_go;
      restart <= 1'b0;
      if (awready)
      begin
        bvalid <= 1'b1;
        bresp <= awaddr == `RBGP_OFS_STATUS ? `RBGP_RESP_OK :
          (awaddr == `RBGP_OFS_CTRL || awaddr == `RBGP_OFS_BURST
          || awaddr == `RBGP_OFS_OCP) ? `RBGP_RESP_OK : `RBGP_RESP_ERR;
        if (awaddr == `RBGP_OFS_CTRL && wstrb[0])
        begin
          ctrl_en <= wdata[`RBGP_CTRL_EN];
          restart <= wdata[`RBGP_CTRL_RESTART];
        end
        if (awaddr == `RBGP_OFS_OCP && wstrb[0])
          ocp_preset <= wdata[3:0];
        for (int k = 0; k < 3; k++)
        begin
          if (awaddr == `RBGP_OFS_BURST && wstrb[k])
            burst_cfg[8*k +: 8] <= wdata[8*k +: 8];
        end
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // bus read side
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (araddr)
      `RBGP_OFS_CTRL:
        rd_mux[`RBGP_CTRL_EN] = ctrl_en;
      `RBGP_OFS_BURST:
        rd_mux = {8'h00, burst_cfg};
      `RBGP_OFS_STATUS:
        rd_mux = {13'h0000, state, 2'h0, su, 3'h0, capacitive_region_flag, 3'h0,
          bulk_overvoltage, fault};
      `RBGP_OFS_OCP:
        rd_mux[3:0] = ocp_preset;
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end
  assign ar_go = arvalid && !arready && !rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RBGP_RESP_OK;
    end
    else
    begin
      arready <= ar_go;
      if (arready)
      begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= (araddr[1:0] == 2'h0) ? `RBGP_RESP_OK : `RBGP_RESP_ERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_slew_turn_on: assert property (
    state == GS_DT_HI && sn.slew_done && run_ok |=> state == GS_LO_ON)
    else $error("slew done did not start low gate");
  a_polarity_turn_on: assert property (
    state == GS_DT_LO && sign_edge && cnt >= 8'(`RBGP_BLANK_CYC) && run_ok && !burst_stop
    |=> state == GS_HI_ON)
    else $error("polarity flip did not start high gate");
  a_dead_time_max: assert property (
    state == GS_DT_HI || state == GS_DT_LO |-> cnt < 8'(`RBGP_MAXDT_CYC))
    else $error("dead time overran its maximum");
  a_polarity_blank: assert property (
    state == GS_DT_HI && run_ok && !sn.slew_done && cnt < 8'(`RBGP_BLANK_CYC)
    |=> state == GS_DT_HI)
    else $error("polarity edge honoured inside blanking");
  a_cap_flag_set: assert property (
    lo_fall && sn.resonant_current_sign |=> capacitive_region_flag && ss_pulldown)
    else $error("capacitive flag not raised");
  a_cap_flag_clear: assert property (
    hi_fall && sn.resonant_current_sign |=> !capacitive_region_flag && !ss_pulldown)
    else $error("capacitive flag not cleared");
  a_boot_uv_gate: assert property (
    sn.boot_uv |=> !upper_switch_on)
    else $error("upper gate on under bootstrap undervoltage");
  a_supply_uv_gate: assert property (
    sn.supply_uv |=> !upper_switch_on && !lower_switch_on)
    else $error("gate on under supply undervoltage");
  a_fault_gates_off: assert property (
    fault != '0 && !restart |=> !upper_switch_on && !lower_switch_on)
    else $error("gate on with latched fault");
  a_avg_high_trip: assert property (
    sn.avg_overcurrent_high && avgh_cnt == CW'(AVGH_CYC - 1) |=> fault.avg_high)
    else $error("high average fault missed");
  a_avg_restart: assert property (
    !sn.avg_overcurrent_high ##1 sn.avg_overcurrent_high |=> avgh_cnt == CW'(1))
    else $error("average timer not restarted");
  a_jfet_temp: assert property (
    sn.over_temp |=> !jfet_on)
    else $error("jfet on during overtemperature");
  a_effort_floor: assert property (
    sn.ss_done |=> control_effort >= $past(burst_threshold))
    else $error("effort below burst threshold");
endmodule : rbgp_top
`default_nettype wire

//--- verif/rbgp_plant.sv
// partner model: half-bridge switch node and resonant current sign comparator
`timescale 1ns/1ps
`default_nettype none
module rbgp_plant (
  input wire logic aclk, // clock
  input wire logic hi, // upper gate command
  input wire logic lo, // lower gate command
  input wire logic [2:0] mode, // 0 slew,1 late flip,2 none,3 capacitive,4 early flip
  output logic slew, // switch node slew finished
  output logic sign // resonant current positive
);
  int dt = 0; // cycles since both gates went off
  logic last = 1'b0; // gate that conducted last, 1 = upper
  // dead-time age and last conducting gate
  always @(posedge aclk)
  begin
    dt <= (hi | lo) ? 0 : dt + 1;
    if (hi | lo)
      last <= hi;
  end
  // slew only in prompt modes; a weak node never finishes
  assign slew = (mode == 3'h0 || mode == 3'h3) && !(hi | lo) && dt >= 2;
  // current keeps its sense into dead time unless a flip mode turns it round
  assign sign = (mode == 3'h3) ^ ((hi | lo) ? hi :
    (((mode == 3'h1 && dt >= 10) || (mode == 3'h4 && dt >= 1)) ? !last : last));
endmodule : rbgp_plant
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the gate timing and protection block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rbgp_pkg::*;
  logic aclk = 1'b0; // 20 MHz clock
  logic aresetn = 1'b0; // sync reset, low
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF; // bus address, strobes
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [31:0] wdata = 32'h0, rdata; // bus data
  logic [1:0] bresp, rresp; // responses
  rbgp_sense_t sn = '0; // bench-driven comparators
  rbgp_sense_t sense_in; // merged with plant outputs
  logic [7:0] comp = 8'h08, ramp = 8'h05, bulk = 8'h00, effort; // effort and input voltage codes
  logic hi, lo, flag, ssp, jfet, gse, bov, slew, sign; // block outputs, plant
  logic hi_q = 1'b0, lo_q = 1'b0; // gate history
  logic [2:0] mode = 3'h0; // plant behaviour
  logic [2:0] mtab [4] = '{3'h0, 3'h1, 3'h2, 3'h4}; // dead-time cases
  int dlo [4] = '{2, 12, 19, 19}; // shortest dead time
  int dhi [4] = '{12, 19, 24, 24}; // longest dead time
  int fail_count = 0, check_count = 0, n_hi = 0, n_lo = 0, n0, n1, d;
  // free-running clock
  always #25 aclk = ~aclk;
  // plant owns slew and sign, bench the rest
  always_comb
  begin
    sense_in = sn;
    sense_in.slew_done = slew;
    sense_in.resonant_current_sign = sign;
  end
  // short average timers keep the run brief
  rbgp_top #(.AVGH_CYC(40), .AVGL_CYC(100)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sense_in(sense_in), .loop_compensator_output(comp),
    .soft_start_ramp(ramp), .bulk_sense(bulk), .upper_switch_on(hi), .lower_switch_on(lo),
    .capacitive_region_flag(flag), .ss_pulldown(ssp), .jfet_on(jfet),
    .gate_supply_en(gse), .bulk_overvoltage(bov), .control_effort(effort));
  rbgp_plant plant (.aclk(aclk), .hi(hi), .lo(lo), .mode(mode), .slew(slew), .sign(sign));
  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // compare a bench count against a window
  task automatic rng(input string nm, input int a, input int b, input int g);
    check_count++;
    if (g < a || g > b)
    begin
      fail_count++;
      $display("[FAIL] %s exp %0d..%0d got %0d", nm, a, b, g);
    end
  endtask : rng
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // edge counts; the gates must never overlap
  always @(posedge aclk)
  begin
    hi_q <= hi;
    lo_q <= lo;
    if (hi && !hi_q)
      n_hi <= n_hi + 1;
    if (lo && !lo_q)
      n_lo <= n_lo + 1;
    if (hi && lo)
      chk("gate overlap", 32'h0, 32'h1);
  end
  // bus write: address and data together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
    input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      t++;
    end
    while (bvalid !== 1'b1 && t < 50);
    bready <= 1'b0;
    chk("bvalid", 32'h1, bvalid);
    chk("bresp", er, bresp);
  endtask : wr
  // bus read, masked compare of the word
  task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] m,
    input logic [31:0] e);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      t++;
    end
    while (rvalid !== 1'b1 && t < 50);
    rready <= 1'b0;
    chk(nm, e, rdata & m);
    chk("rresp", (a[1:0] == 2'h0) ? 32'h0 : 32'h2, rresp);
  endtask : rc
  // no new upper pulses, and the status fault bits read back as given
  task automatic held(input string nm, input logic [3:0] f);
    n0 = n_hi;
    cyc(100);
    chk(nm, n0, n_hi);
    rc(nm, 4'h8, 32'hF, f);
  endtask : held
  // inputs cleared first, since a standing fault wins over restart
  task automatic restart;
    cyc(8);
    wr(4'h0, 32'h3, 4'hF, 2'h0);
    n0 = n_hi;
    cyc(150);
    rng("restart", n0 + 1, n0 + 99, n_hi);
  endtask : restart
  // one average comparator: early read clean, longer hold trips
  task automatic avg(input logic s, input int n, input logic [3:0] f);
    sn.avg_overcurrent_high <= !s;
    sn.avg_overcurrent_low <= s;
    cyc(n * 3 / 4);
    rc("avg early", 4'h8, 32'hF, 32'h0);
    cyc(n / 2);
    sn.avg_overcurrent_high <= 1'b0;
    sn.avg_overcurrent_low <= 1'b0;
    held("avg fault", f);
    restart;
  endtask : avg
  // single verdict point
  task automatic end_sim;
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // hang guard, well beyond the expected run
  initial
  begin
    #(50 * 40000);
    fail_count++;
    end_sim;
  end
  // main sequence
  initial
  begin
    cyc(2);
    aresetn <= 1'b1;
    cyc(3);
    chk("jfet at power-up", 32'h1, jfet);
    rc("ctrl reset", 4'h0, 32'hFFFFFFFF, 32'h1);
    rc("burst reset", 4'h4, 32'hFFFFFFFF, 32'h040010);
    rc("ocp reset", 4'hC, 32'hFFFFFFFF, 32'h4);
    wr(4'h8, 32'hFFFFFFFF, 4'hF, 2'h0);
    rc("status ro", 4'h8, 32'hFFFFFFFF, 32'h0);
    wr(4'h2, 32'hFFFFFFFF, 4'hF, 2'h2);
    rc("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
    wr(4'h4, 32'hFFFFFFAA, 4'h1, 2'h0);
    rc("burst strobe", 4'h4, 32'hFFFFFFFF, 32'h0400AA);
    wr(4'h4, 32'h040020, 4'hF, 2'h0);
    sn.supply_start <= 1'b1;
    cyc(10);
    chk("jfet off", 32'h0, jfet);
    chk("supply on", 32'h1, gse);
    cyc(20);
    chk("wait for pfc", 32'h0, n_hi);
    sn.peak_overcurrent <= 1'b1;
    sn.pfc_ready <= 1'b1;
    cyc(12);
    chk("effort in soft start", 32'h05, effort);
    cyc(900);
    rng("peak trip cycle", 19, 20, n_hi);
    sn.peak_overcurrent <= 1'b0;
    held("peak fault", 4'h1);
    restart;
    for (int i = 0; i < 4; i++)
    begin
      mode <= mtab[i];
      cyc(80);
      for (int t = 0; t < 200 && !(hi_q && !hi); t++)
        cyc(1);
      for (d = 0; !lo && d < 60; d++)
        cyc(1);
      rng("dead time", dlo[i], dhi[i], d);
    end
    mode <= 3'h3;
    cyc(150);
    chk("capacitive seen", 32'h3, {flag, ssp});
    mode <= 3'h0;
    cyc(150);
    chk("capacitive clear", 32'h0, {flag, ssp});
    sn.boot_uv <= 1'b1;
    cyc(10);
    n0 = n_hi;
    n1 = n_lo;
    cyc(200);
    chk("boot uv upper", n0, n_hi);
    rng("boot uv lower", n1 + 1, n1 + 99, n_lo);
    sn.boot_uv <= 1'b0;
    sn.supply_uv <= 1'b1;
    cyc(10);
    n1 = n_lo;
    held("supply uv", 4'h0);
    chk("supply uv lower", n1, n_lo);
    sn.supply_uv <= 1'b0;
    cyc(60);
    repeat (2)
    begin
      sn.avg_overcurrent_high <= 1'b1;
      cyc(30);
      sn.avg_overcurrent_high <= 1'b0;
      cyc(10);
    end
    rc("avg timer rezero", 4'h8, 32'hF, 32'h0);
    avg(1'b0, 40, 4'h2);
    avg(1'b1, 100, 4'h4);
    sn.over_temp <= 1'b1;
    cyc(10);
    sn.over_temp <= 1'b0;
    held("over temp", 4'h8);
    restart;
    sn.bulk_cmp <= 1'b1;
    cyc(10);
    chk("bulk fault", 32'h1, bov);
    held("bulk stop", 4'h0);
    sn.bulk_cmp <= 1'b0;
    cyc(10);
    chk("bulk clear", 32'h0, bov);
    sn.ss_done <= 1'b1;
    sn.cap_at_cm <= 1'b1;
    comp <= 8'h30;
    cyc(40);
    chk("effort comp", 32'h30, effort);
    n0 = n_hi;
    cyc(300);
    rng("continuous", n0 + 2, n0 + 9, n_hi);
    // enter burst right after a high-side fall, so no pulse straddles the count
    for (int t = 0; t < 200 && !(hi_q && !hi); t++)
      cyc(1);
    comp <= 8'h08;
    n0 = n_hi;
    cyc(12);
    chk("effort threshold", 32'h20, effort);
    cyc(800);
    rng("burst pulses", n0 + 4, n0 + 5, n_hi);
    held("burst stop", 4'h0);
    bulk <= 8'h80;
    wr(4'h4, 32'h044020, 4'hF, 2'h0);
    cyc(12);
    chk("adaptive threshold", 32'h40, effort);
    comp <= 8'h50;
    n0 = n_hi;
    cyc(300);
    rng("burst exit", n0 + 1, n0 + 9, n_hi);
    aresetn <= 1'b0;
    sn <= '0;
    cyc(4);
    aresetn <= 1'b1;
    cyc(6);
    sn.over_temp <= 1'b1;
    cyc(10);
    chk("jfet over temp", 32'h0, jfet);
    end_sim;
  end
endmodule : tb
`default_nettype wire
